// ### rsos_pkg.sv
// Package of types and constants for the remote status output selector.
package rsos_pkg;

   // ----------------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------------
   localparam int unsigned NUM_IN      = 7;
   localparam int unsigned NUM_OUT     = 4;
   localparam int unsigned ITEM_W      = 4;
   localparam logic [3:0]  ITEM_FIRST  = 4'h0;
   localparam logic [3:0]  ITEM_OUT0   = 4'h7;
   localparam logic [3:0]  ITEM_LAST   = 4'ha;
   localparam logic [2:0]  IN_SEL_LAST = 3'h6;
   localparam logic [4:0]  COND_LAST   = 5'h11;

   // ----------------------------------------------------------------------
   // Selectable output conditions, in the order the setup steps through them
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      RSOS_C_OFF, RSOS_C_ON, RSOS_C_BYPASS, RSOS_C_LIVE, RSOS_C_WFS, RSOS_C_FULL,
      RSOS_C_SAFE, RSOS_C_WAIT_EXIT, RSOS_C_RAMP, RSOS_C_CATCHUP_MODE, RSOS_C_CATCHUP,
      RSOS_C_MUTE, RSOS_C_DUMP, RSOS_C_UNLOCK, RSOS_C_BREAK, RSOS_C_READY,
      RSOS_C_ERROR, RSOS_C_ALL_OK
   } rsos_cond_e;

   // Remote input functions, in the order the setup steps through them.
   typedef enum logic [2:0] {
      RSOS_I_NONE, RSOS_I_DUMP, RSOS_I_SNEEZE, RSOS_I_MUTE, RSOS_I_BYPASS,
      RSOS_I_WFS, RSOS_I_RAMP
   } rsos_in_e;

   // State reported by the delay engine.
   typedef struct packed {
      logic bypassed;
      logic at_zero;
      logic wfs_active;
      logic at_full;
      logic above_safe;
      logic wait_exit_active;
      logic ramp_active;
      logic catchup_mode;
      logic at_max;
      logic mute_active;
      logic sneeze_active;
      logic dump_active;
      logic digital_selected;
      logic digital_valid;
      logic break_active;
      logic run_time;
      logic error_logged;
   } rsos_status_s;

   // One-cycle button presses, from the front panel or emulated by remote inputs.
   typedef struct packed {
      logic configure;
      logic bypass;
      logic wait_exit;
      logic ramp;
      logic dump;
      logic wfs;
   } rsos_btn_s;

   // Held functions emulated by remote inputs.
   typedef struct packed {
      logic mute;
      logic sneeze;
   } rsos_hold_s;

endpackage

// ### rsos_top.sv
// Remote status outputs, remote button inputs and their setup for the delay unit.
// How it works
// - Unassigned output stays high impedance, default off
// - Safe output closes while delay exceeds safe
// - Ramp output closes only while ramping to zero
// - Catch-up mode output closes growing or at max
// - Catch-up outputs off during sneeze or mute
// - Active catch-up output closes only while growing
// - Mute output closes while mute operated
// - Dump output closes while dump operated
// - Unlock closes when digital input lacks signal
// - Break output closes during station break insert
// - Ready closes in run-time accepting commands
// - Error output closes while error log nonempty
// - All-OK closes when log empty and ready
// - Remote dump input acts as panel dump
// - Dump lamp and safe output change together
// - Setup: wait steps item, ramp cycles value
// - Setup only from bypass, bypass exits setup
// - Wait-for-safe builds delay fast until safe
`timescale 1ns/1ps

module rsos_top
   import rsos_pkg::*;
#(
   parameter int unsigned N_IN  = rsos_pkg::NUM_IN,
   parameter int unsigned N_OUT = rsos_pkg::NUM_OUT
)
(
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Delay engine state and panel presses.
   input  wire rsos_pkg::rsos_status_s status,
   input  wire rsos_pkg::rsos_btn_s    panel_btn,
   // Remote contact inputs, high while the contact is closed.
   input  wire logic [N_IN-1:0]      remote_in,
   // Open-collector outputs: data is always low, enable low pulls to ground.
   output logic [N_OUT-1:0]          oc_out_r,
   output logic [N_OUT-1:0]          oc_oe_n_r,
   // Presses and holds sent to the delay engine.
   output rsos_pkg::rsos_btn_s       engine_btn_r,
   output rsos_pkg::rsos_hold_s      engine_hold_r,
   output logic                      fast_build_r,
   // Front panel lamps and setup state.
   output logic                      dump_lamp_r,
   output logic                      bypass_lamp_r,
   output logic                      cfg_mode_r,
   output logic [ITEM_W-1:0]         cfg_item_r
);
   import rsos_pkg::*;

   // ----------------------------------------------------------------------
   // Condition decode
   // ----------------------------------------------------------------------

   // Whether the selected condition currently holds.
   function automatic logic cond_true(input rsos_cond_e sel, input rsos_status_s s);
      logic quiet;
      logic ready;
      quiet = s.mute_active | s.sneeze_active;
      ready = s.run_time;
      unique case (sel)
         RSOS_C_OFF:          cond_true = 1'b0;
         RSOS_C_ON:           cond_true = 1'b1;
         RSOS_C_BYPASS:       cond_true = s.bypassed;
         RSOS_C_LIVE:         cond_true = !s.bypassed && s.at_zero;
         RSOS_C_WFS:          cond_true = s.wfs_active;
         RSOS_C_FULL:         cond_true = s.at_full;
         RSOS_C_SAFE:         cond_true = s.above_safe;
         RSOS_C_WAIT_EXIT:    cond_true = s.wait_exit_active;
         RSOS_C_RAMP:         cond_true = s.ramp_active;
         RSOS_C_CATCHUP_MODE: cond_true = s.catchup_mode && !quiet;
         RSOS_C_CATCHUP:      cond_true = s.catchup_mode && !s.at_max && !quiet;
         RSOS_C_MUTE:         cond_true = s.mute_active;
         RSOS_C_DUMP:         cond_true = s.dump_active;
         RSOS_C_UNLOCK:       cond_true = s.digital_selected && !s.digital_valid;
         RSOS_C_BREAK:        cond_true = s.break_active;
         RSOS_C_READY:        cond_true = ready;
         RSOS_C_ERROR:        cond_true = s.error_logged;
         RSOS_C_ALL_OK:       cond_true = ready && !s.error_logged;
         default:             cond_true = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Setup storage
   // ----------------------------------------------------------------------

   // Assignments live in flops; a real unit would mirror them to non-volatile memory.
   rsos_in_e          in_sel_r  [N_IN];
   rsos_cond_e        out_sel_r [N_OUT];
   logic [N_IN-1:0]   remote_q_r;
   logic [N_IN-1:0]   remote_rise;
   logic              cfg_enter;
   logic              cfg_exit;
   logic              item_is_out;
   logic [ITEM_W-1:0] out_idx;
   logic [ITEM_W-1:0] item_nxt;
   rsos_btn_s         emu_btn;
   rsos_hold_s        emu_hold;

   // Setup can only be entered from bypass; a press elsewhere is ignored.
   assign cfg_enter   = !cfg_mode_r && panel_btn.configure && status.bypassed;
   assign cfg_exit    = cfg_mode_r && panel_btn.bypass;
   assign item_is_out = cfg_item_r >= ITEM_OUT0;
   assign out_idx     = cfg_item_r - ITEM_OUT0;
   assign item_nxt    = (cfg_item_r == ITEM_LAST) ? ITEM_FIRST : cfg_item_r + 4'h1;

   // Setup mode flag.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         cfg_mode_r <= 1'b0;
      else if (cfg_enter)
         cfg_mode_r <= 1'b1;
      else if (cfg_exit)
         cfg_mode_r <= 1'b0;
   end

   // Wait-and-exit steps to the next item, wrapping after the last output.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         cfg_item_r <= ITEM_FIRST;
      else if (cfg_enter)
         cfg_item_r <= ITEM_FIRST;
      else if (cfg_mode_r && panel_btn.wait_exit)
         cfg_item_r <= item_nxt;
   end

   // Ramp presses cycle the value of the selected item.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < N_IN; i++)
            in_sel_r[i] <= RSOS_I_NONE;
         for (int j = 0; j < N_OUT; j++)
            out_sel_r[j] <= RSOS_C_OFF;
      end
      else if (cfg_mode_r && panel_btn.ramp && !panel_btn.wait_exit)
      begin
         for (int i = 0; i < N_IN; i++)
            if (!item_is_out && cfg_item_r == ITEM_W'(i))
               in_sel_r[i] <= (in_sel_r[i] == IN_SEL_LAST) ? RSOS_I_NONE
                                                           : rsos_in_e'(in_sel_r[i] + 3'h1);
         for (int j = 0; j < N_OUT; j++)
            if (item_is_out && out_idx == ITEM_W'(j))
               out_sel_r[j] <= (out_sel_r[j] == COND_LAST) ? RSOS_C_OFF
                                                           : rsos_cond_e'(out_sel_r[j] + 5'h01);
      end
   end

   // ----------------------------------------------------------------------
   // Remote button emulation
   // ----------------------------------------------------------------------

   // Inputs arrive synchronous; presses act on the closing edge only.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         remote_q_r <= '0;
      else
         remote_q_r <= remote_in;
   end
   assign remote_rise = remote_in & ~remote_q_r;

   // Map each remote input onto the button or hold it stands for.
   always_comb
   begin
      emu_btn  = '0;
      emu_hold = '0;
      for (int i = 0; i < N_IN; i++)
      begin
         unique case (in_sel_r[i])
            RSOS_I_NONE:   ;
            RSOS_I_DUMP:   emu_btn.dump   = emu_btn.dump   | remote_rise[i];
            RSOS_I_SNEEZE: emu_hold.sneeze = emu_hold.sneeze | remote_in[i];
            RSOS_I_MUTE:   emu_hold.mute  = emu_hold.mute  | remote_in[i];
            RSOS_I_BYPASS: emu_btn.bypass = emu_btn.bypass | remote_rise[i];
            RSOS_I_WFS:    emu_btn.wfs    = emu_btn.wfs    | remote_rise[i];
            RSOS_I_RAMP:   emu_btn.ramp   = emu_btn.ramp   | remote_rise[i];
            default:       ;
         endcase
      end
   end

   // Panel and remote presses merge; in setup the panel keys are consumed locally.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         engine_btn_r  <= '0;
         engine_hold_r <= '0;
      end
      else if (cfg_mode_r || cfg_enter)
      begin
         engine_btn_r  <= '0;
         engine_hold_r <= '0;
      end
      else
      begin
         engine_btn_r  <= panel_btn | emu_btn;
         engine_hold_r <= emu_hold;
      end
   end

   // Wait-for-safe asks for fast build while in-line and short of safe.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         fast_build_r <= 1'b0;
      else
         fast_build_r <= status.wfs_active && !status.bypassed && !status.above_safe;
   end

   // ----------------------------------------------------------------------
   // Outputs and lamps
   // ----------------------------------------------------------------------

   // Recomputed every cycle so a mode change shows on the next edge.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         oc_out_r  <= '0;
         oc_oe_n_r <= '1;
      end
      else
      begin
         oc_out_r <= '0;
         for (int j = 0; j < N_OUT; j++)
            oc_oe_n_r[j] <= !cond_true(out_sel_r[j], status);
      end
   end

   // The dump lamp uses the same flop timing as the outputs so both change together.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         dump_lamp_r <= 1'b0;
      else
         dump_lamp_r <= status.above_safe;
   end

   // Bypass lamp is lit in bypass, and so throughout setup.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         bypass_lamp_r <= 1'b0;
      else
         bypass_lamp_r <= status.bypassed || cfg_mode_r || cfg_enter;
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_off_stays_hiz: assert property (
      (out_sel_r[0] == RSOS_C_OFF) |=> oc_oe_n_r[0])
      else $error("Unassigned output was driven.");

   chk_safe_follows: assert property (
      (out_sel_r[0] == RSOS_C_SAFE) |=> (oc_oe_n_r[0] == !$past(status.above_safe)))
      else $error("Safe output did not follow safe state.");

   chk_catchup_quiet: assert property (
      ((out_sel_r[3] == RSOS_C_CATCHUP_MODE || out_sel_r[3] == RSOS_C_CATCHUP)
       && (status.mute_active || status.sneeze_active)) |=> oc_oe_n_r[3])
      else $error("Catch-up output driven during mute or sneeze.");

   chk_catchup_max: assert property (
      (out_sel_r[3] == RSOS_C_CATCHUP && status.at_max) |=> oc_oe_n_r[3])
      else $error("Active catch-up output driven at max delay.");

   chk_all_ok_err: assert property (
      (out_sel_r[3] == RSOS_C_ALL_OK) |=>
      (!oc_oe_n_r[3] == ($past(status.run_time) && !$past(status.error_logged))))
      else $error("All-OK output wrong.");

   chk_remote_dump: assert property (
      (!cfg_mode_r && in_sel_r[0] == RSOS_I_DUMP && remote_in[0] && !remote_q_r[0]
       && !panel_btn.configure) |=> engine_btn_r.dump
      ##1 (!engine_btn_r.dump || $past(remote_rise != '0) || $past(panel_btn.dump)))
      else $error("Remote dump did not give a single press.");

   chk_lamp_with_safe: assert property (
      (out_sel_r[0] == RSOS_C_SAFE) |=> (dump_lamp_r == !oc_oe_n_r[0]))
      else $error("Dump lamp and safe output disagree.");

   chk_item_step: assert property (
      (cfg_mode_r && panel_btn.wait_exit && !panel_btn.bypass && cfg_item_r == ITEM_LAST)
      |=> cfg_item_r == ITEM_FIRST)
      else $error("Item did not wrap after the last output.");

   chk_cfg_from_bypass: assert property (
      $rose(cfg_mode_r) |-> $past(status.bypassed) ##0 bypass_lamp_r)
      else $error("Setup entered outside bypass.");

   chk_cfg_exit: assert property (
      (cfg_mode_r && panel_btn.bypass) |=> !cfg_mode_r ##1 (bypass_lamp_r == $past(status.bypassed)))
      else $error("Bypass press did not end setup.");

   chk_fast_build: assert property (
      (status.wfs_active && !status.bypassed && !status.above_safe) [*2] |-> fast_build_r)
      else $error("Fast build missing during wait-for-safe.");

   chk_ramp_track: assert property (
      (out_sel_r[3] == RSOS_C_RAMP) [*2] |-> (oc_oe_n_r[3] == !$past(status.ramp_active)))
      else $error("Ramp output did not track ramping.");

   chk_mute_output: assert property (
      (out_sel_r[3] == RSOS_C_MUTE) |=> (oc_oe_n_r[3] == !$past(status.mute_active)))
      else $error("Mute output did not follow mute.");

   chk_dump_output: assert property (
      (out_sel_r[3] == RSOS_C_DUMP) |=> (oc_oe_n_r[3] == !$past(status.dump_active)))
      else $error("Dump output did not follow dump.");

   chk_unlock_output: assert property (
      (out_sel_r[3] == RSOS_C_UNLOCK) |=>
      (oc_oe_n_r[3] == !($past(status.digital_selected) && !$past(status.digital_valid))))
      else $error("Unlock output wrong.");

   chk_break_output: assert property (
      (out_sel_r[3] == RSOS_C_BREAK) |=> (oc_oe_n_r[3] == !$past(status.break_active)))
      else $error("Break output did not follow station break.");

   chk_ready_output: assert property (
      (out_sel_r[3] == RSOS_C_READY) |=> (oc_oe_n_r[3] == !$past(status.run_time)))
      else $error("Ready output did not follow run-time.");

   chk_error_output: assert property (
      (out_sel_r[3] == RSOS_C_ERROR) |=> (oc_oe_n_r[3] == !$past(status.error_logged)))
      else $error("Error output did not follow the error log.");

   chk_cfg_refused: assert property (
      (!cfg_mode_r && !status.bypassed) |=> !cfg_mode_r)
      else $error("Setup entered while in-line.");

   cov_safe_close: cover property (out_sel_r[0] == RSOS_C_SAFE && !oc_oe_n_r[0]);
   cov_cfg_round: cover property ($rose(cfg_mode_r) ##[1:40] $fell(cfg_mode_r));
   cov_remote_dump: cover property (engine_btn_r.dump && in_sel_r[0] == RSOS_I_DUMP);
   cov_item_wrap: cover property (cfg_mode_r && cfg_item_r == ITEM_LAST ##1 cfg_item_r == ITEM_FIRST);
   cov_catchup_mute: cover property (out_sel_r[3] == RSOS_C_CATCHUP && status.catchup_mode
                                     && status.mute_active);

endmodule

// ### rsos_relay_model.sv
// Behavioural model of the relays and contact switches wired to the remote connector.
`timescale 1ns/1ps

module rsos_relay_model
   import rsos_pkg::*;
#(
   parameter int unsigned N_IN  = 7,
   parameter int unsigned N_OUT = 4
)
(
   // Open-collector drive from the unit.
   input  wire logic [N_OUT-1:0] oc_out,
   input  wire logic [N_OUT-1:0] oc_oe_n,
   // Switch positions asked for by the bench.
   input  wire logic [N_IN-1:0]  switch_closed,
   // Resolved relay coil lines and contact inputs.
   output logic [N_OUT-1:0]      line,
   output logic [N_IN-1:0]       remote_in
);
   // The coil pull-up wins unless the unit pulls the line, so a released line never shows old data.
   always_comb
   begin
      for (int j = 0; j < N_OUT; j++)
      begin
         line[j] = oc_oe_n[j] ? 1'b1 : oc_out[j];
      end
   end

   // Dry contacts close straight onto the inputs; there is no bounce in this model.
   assign remote_in = switch_closed;
endmodule

// ### rsos_top_tb.sv
// Self-checking testbench for the remote status output selector.
`timescale 1ns/1ps

module rsos_top_tb;
   import rsos_pkg::*;

   // ----------------------------------------------------------------------
   // Signals and button codes
   // ----------------------------------------------------------------------
   localparam rsos_btn_s    B_CFG  = 6'h20;
   localparam rsos_btn_s    B_BYP  = 6'h10;
   localparam rsos_btn_s    B_WAIT = 6'h08;
   localparam rsos_btn_s    B_RAMP = 6'h04;
   localparam rsos_btn_s    B_DUMP = 6'h02;
   localparam rsos_status_s S_BYP  = 17'h10000;
   localparam rsos_btn_s    B_WFS  = 6'h01;
   logic                    clk;
   logic                    resetn;
   rsos_status_s            status;
   rsos_status_s            s_pat;
   rsos_btn_s               panel_btn;
   rsos_btn_s               engine_btn_r;
   rsos_hold_s              engine_hold_r;
   rsos_btn_s               exp_btn;
   rsos_hold_s              exp_hold;
   logic [6:0]              switch_closed;
   logic [6:0]              remote_in;
   logic [3:0]              oc_out_r;
   logic [3:0]              oc_oe_n_r;
   logic [3:0]              line;
   logic                    fast_build_r;
   logic                    dump_lamp_r;
   logic                    bypass_lamp_r;
   logic                    cfg_mode_r;
   logic [3:0]              cfg_item_r;
   int                      n_mismatch;
   int                      cmp_count;
   int                      cycles;

   rsos_top i_dut (.clk(clk), .resetn(resetn), .status(status), .panel_btn(panel_btn), .remote_in(remote_in),
      .oc_out_r(oc_out_r), .oc_oe_n_r(oc_oe_n_r), .engine_btn_r(engine_btn_r), .engine_hold_r(engine_hold_r),
      .fast_build_r(fast_build_r), .dump_lamp_r(dump_lamp_r), .bypass_lamp_r(bypass_lamp_r),
      .cfg_mode_r(cfg_mode_r), .cfg_item_r(cfg_item_r));

   rsos_relay_model i_relay (.oc_out(oc_out_r), .oc_oe_n(oc_oe_n_r), .switch_closed(switch_closed),
      .line(line), .remote_in(remote_in));

   // The clock runs at 100 MHz.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Expected closure for each selectable condition, worked out independently of the design.
   function automatic logic exp_cond(input logic [4:0] c, input rsos_status_s s);
      case (c)
         RSOS_C_ON:           return 1'b1;
         RSOS_C_BYPASS:       return s.bypassed;
         RSOS_C_LIVE:         return !s.bypassed && s.at_zero;
         RSOS_C_WFS:          return s.wfs_active;
         RSOS_C_FULL:         return s.at_full;
         RSOS_C_SAFE:         return s.above_safe;
         RSOS_C_WAIT_EXIT:    return s.wait_exit_active;
         RSOS_C_RAMP:         return s.ramp_active;
         RSOS_C_CATCHUP_MODE: return s.catchup_mode && !s.mute_active && !s.sneeze_active;
         RSOS_C_CATCHUP:      return s.catchup_mode && !s.mute_active && !s.sneeze_active && !s.at_max;
         RSOS_C_MUTE:         return s.mute_active;
         RSOS_C_DUMP:         return s.dump_active;
         RSOS_C_UNLOCK:       return s.digital_selected && !s.digital_valid;
         RSOS_C_BREAK:        return s.break_active;
         RSOS_C_READY:        return s.run_time;
         RSOS_C_ERROR:        return s.error_logged;
         RSOS_C_ALL_OK:       return s.run_time && !s.error_logged;
         default:             return 1'b0;
      endcase
   endfunction

   // Compares one observed value with its expectation.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // A panel press is a one-cycle pulse; the caller looks at the answer one step after return.
   task automatic press(input rsos_btn_s b);
      @(posedge clk);
      panel_btn <= b;
      @(posedge clk);
      panel_btn <= '0;
   endtask

   // Applies engine state and waits until the registered outputs reflect it.
   task automatic set_status(input rsos_status_s s);
      @(posedge clk);
      status <= s;
      @(posedge clk);
      #1;
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A hang is cut short well beyond the fewer than 1500 cycles the sequence needs.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      status = '0;
      panel_btn = '0;
      switch_closed = '0;
      resetn = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk("oe_n after reset", oc_oe_n_r, 4'hf);
      chk("relay lines after reset", line, 4'hf);
      chk("oc data", oc_out_r, 4'h0);
      // Setup must be refused while the unit is in-line.
      press(B_CFG);
      #1;
      chk("setup from in-line", cfg_mode_r, 1'b0);
      set_status(S_BYP);
      press(B_CFG);
      #1;
      chk("setup from bypass", cfg_mode_r, 1'b1);
      chk("bypass lamp in setup", bypass_lamp_r, 1'b1);
      press(B_RAMP);
      repeat (7) press(B_WAIT);
      #1;
      chk("setup item", cfg_item_r, 4'h7);
      repeat (6) press(B_RAMP);
      press(B_BYP);
      #1;
      chk("setup exit", cfg_mode_r, 1'b0);
      // Output 4 is stepped through every condition; each is tried against a set of engine states.
      for (int c = 0; c <= 17; c++)
      begin
         if (c != 0)
         begin
            set_status(S_BYP);
            press(B_CFG);
            repeat (10) press(B_WAIT);
            press(B_RAMP);
            press(B_BYP);
         end
         for (int p = 0; p <= 18; p++)
         begin
            s_pat = (p == 17) ? '1 : (p == 18) ? '0 : rsos_status_s'(17'h1 << p);
            set_status(s_pat);
            chk("output 4 drive", oc_oe_n_r[3], !exp_cond(c[4:0], s_pat));
            chk("output 1 safe", oc_oe_n_r[0], !s_pat.above_safe);
            chk("dump lamp", dump_lamp_r, s_pat.above_safe);
            chk("unassigned outputs", oc_oe_n_r[2:1], 2'h3);
            chk("fast build", fast_build_r, s_pat.wfs_active && !s_pat.bypassed && !s_pat.above_safe);
         end
      end
      // Remote input 1 was set to dump; its closing edge gives a single engine press.
      set_status('0);
      @(posedge clk);
      switch_closed <= 7'h01;
      @(posedge clk);
      #1;
      chk("remote dump press", engine_btn_r, B_DUMP);
      @(posedge clk);
      #1;
      chk("remote dump pulse end", engine_btn_r, 6'h00);
      press(B_DUMP);
      #1;
      chk("panel dump press", engine_btn_r, B_DUMP);
      // The item wraps from the last output back to input 1.
      set_status(S_BYP);
      press(B_CFG);
      repeat (11) press(B_WAIT);
      #1;
      chk("setup item wrap", cfg_item_r, 4'h0);
      press(B_BYP);
      // Remote input 2 steps through every function; each closing gives its press or hold.
      for (int v = 1; v <= 6; v++)
      begin
         exp_btn  = (v == 1) ? B_DUMP : (v == 4) ? B_BYP : (v == 5) ? B_WFS : (v == 6) ? B_RAMP : 6'h00;
         exp_hold = (v == 2) ? 2'h1 : (v == 3) ? 2'h2 : 2'h0;
         set_status(S_BYP);
         press(B_CFG);
         press(B_WAIT);
         press(B_RAMP);
         press(B_BYP);
         set_status('0);
         @(posedge clk);
         switch_closed <= 7'h03;
         @(posedge clk);
         #1;
         chk("remote press", engine_btn_r, exp_btn);
         chk("remote hold", engine_hold_r, exp_hold);
         @(posedge clk);
         #1;
         chk("remote press end", engine_btn_r, 6'h00);
         chk("remote hold stays", engine_hold_r, exp_hold);
         @(posedge clk);
         switch_closed <= 7'h01;
      end
      give_verdict();
   end
endmodule
